// ### design/zone_sel_pkg.sv
// constants and types shared by the zone output and area select block
package zone_sel_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_HZ           = 100_000_000;
   localparam int SETTLE_DEFAULT_MS = 30;
   localparam int CYCLES_PER_MS    = CLK_HZ / 1000;

   // ************************************************************
   // selection inputs and area space
   // ************************************************************
   localparam int MAX_PAIRS      = 5;
   localparam int MAX_AREAS      = 32;
   localparam int MAX_PAIRS_EDM  = 4;
   localparam int MAX_PAIRS_DUAL = 4;
   localparam int MAX_PAIRS_MUTE = 2;
   localparam int MAX_PAIRS_ENC  = 2;
   localparam int NUM_PATTERNS   = 4;

   // ************************************************************
   // register offsets (byte addresses)
   // ************************************************************
   localparam logic [7:0] ADDR_CONFIG    = 8'h00;
   localparam logic [7:0] ADDR_DELAY     = 8'h04;
   localparam logic [7:0] ADDR_PAT_KIND  = 8'h08;
   localparam logic [7:0] ADDR_PAT_AREA  = 8'h0C;
   localparam logic [7:0] ADDR_STATUS    = 8'h10;

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int CFG_PAIRS_LSB = 0;
   localparam int CFG_DUAL_BIT  = 3;
   localparam int CFG_ENC_BIT   = 4;
   localparam int CFG_MUTE_BIT  = 5;
   localparam int CFG_EDM_BIT   = 6;
   localparam logic [31:0] CONFIG_RESET   = 32'h0000_0005;
   localparam logic [31:0] DELAY_RESET    = 32'h0000_001E;
   localparam logic [31:0] PAT_KIND_RESET = 32'h0000_00AA;
   localparam logic [31:0] PAT_AREA_RESET = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // kind of an encoder-mode input pattern
   localparam logic [1:0] PAT_UNUSED  = 2'h0;
   localparam logic [1:0] PAT_STATIC  = 2'h1;
   localparam logic [1:0] PAT_ENCODER = 2'h2;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [4:0] true_line;
      logic [4:0] inv_line;
   } sel_pins_t;

   typedef struct packed {
      logic prot1;
      logic prot2;
      logic warn1;
      logic warn2;
   } zone_hits_t;

   typedef enum logic [0:0] {SETTLE_IDLE, SETTLE_WAIT} settle_state_t;

   // all state of the block
   typedef struct packed {
      sel_pins_t     sync1;
      sel_pins_t     sync2;
      logic [5:0]    cand;        // {error, decoded index}
      settle_state_t settle;
      logic [16:0]   pre_cnt;
      logic [7:0]    ms_cnt;
      logic [4:0]    active_idx;
      logic          active_err;
      logic [4:0]    active_area;
      logic          fail;
      logic          dual_eff;
      logic [3:0]    safe_out;    // zone1 a,b zone2 a,b
      logic [1:0]    warn_out;
      logic [6:0]    seg_tens;
      logic [6:0]    seg_ones;
      logic [31:0]   config_reg;
      logic [31:0]   delay_reg;
      logic [31:0]   pat_kind;
      logic [31:0]   pat_area;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
   } zone_state_t;

endpackage : zone_sel_pkg

// ### design/zone_output_area_select.sv
// zone to output mapping and area selection with an AXI4-Lite register file
// What this block does
// RQ1: one of 32 area sets is always active
// RQ2: protection plus two warnings, or dual protection
// RQ3: dual protection disables warning zone evaluation
// RQ4: obstacle in protection zone turns safety pair off
// RQ5: dual mode: pair one zone1, pair two zone2
// RQ6: obstacle in warning zone turns warning off
// RQ7: warning and safety outputs evaluated independently
// RQ8: controller drives every pair true and inverted
// RQ9: equal levels on a used pair flag error
// RQ10: seven-segment display shows active area number
// RQ11: settling delay before area change, default 30ms
// RQ12: up to five pairs address 32 areas
// RQ13: five pairs: one plus binary, off counts one
// RQ14: four pairs: sixteen areas, same binary decoding
// RQ15: enabled functions limit usable pairs and areas
// RQ16: encoder mode forbids muting and dual protection
// RQ17: encoder mode: four patterns, one must be encoder
// RQ18: encoder pattern maps speed onto 32 areas
// RQ19: three pairs: eight areas, same binary decoding
// RQ20: two pairs four areas, one pair two
// RQ21: selection error forces all safety outputs off
// RQ22: unused higher pairs ignored for decode, checking
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module zone_output_area_select #(
   parameter int CYCLES_PER_MS = zone_sel_pkg::CYCLES_PER_MS
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire zone_sel_pkg::sel_pins_t sel_pins,
   input  wire zone_sel_pkg::zone_hits_t zone_hits,
   input  wire logic [4:0]             encoder_area,
   input  wire logic [31:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [31:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic                        zone1_safe_out_a,
   output logic                        zone1_safe_out_b,
   output logic                        zone2_safe_out_a,
   output logic                        zone2_safe_out_b,
   output logic                        warn_zone_out_1,
   output logic                        warn_zone_out_2,
   output logic [4:0]                  active_area,
   output logic                        input_error,
   output logic [6:0]                  seg_tens,
   output logic [6:0]                  seg_ones
);

   // ************************************************************
   // helpers
   // ************************************************************

   // segment pattern gfedcba for one decimal digit
   function automatic logic [6:0] seg7(input logic [3:0] d);
      logic [6:0] s;
      s = 7'h00;
      case (d)
         4'h0: s = 7'h3F;
         4'h1: s = 7'h06;
         4'h2: s = 7'h5B;
         4'h3: s = 7'h4F;
         4'h4: s = 7'h66;
         4'h5: s = 7'h6D;
         4'h6: s = 7'h7D;
         4'h7: s = 7'h07;
         4'h8: s = 7'h7F;
         4'h9: s = 7'h6F;
         default: s = 7'h00;
      endcase
      return s;
   endfunction : seg7

   // merge write data into a register under byte enables
   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction : apply_strb

   // ************************************************************
   // state
   // ************************************************************
   zone_sel_pkg::zone_state_t st;
   zone_sel_pkg::zone_state_t next_st;

   logic [2:0]  cfg_pairs;
   logic [2:0]  max_pairs;
   logic [2:0]  eff_pairs;
   logic        enc_mode;
   logic        dual_req;
   logic [4:0]  used_mask;
   logic [4:0]  raw_idx;
   logic        raw_err;
   logic [5:0]  raw;
   logic [1:0]  pat_sel;
   logic [1:0]  sel_kind;
   logic        any_enc;
   logic        cfg_err;
   logic [4:0]  area_idx;
   logic [5:0]  area_num;
   logic        commit;
   logic        wr_go;
   logic        rd_go;
   logic        wr_hit;
   logic [31:0] rd_val;
   logic        rd_hit;

   // mode limits: encoder excludes muting and dual protection
   always_comb
   begin
      enc_mode  = st.config_reg[zone_sel_pkg::CFG_ENC_BIT];
      dual_req  = st.config_reg[zone_sel_pkg::CFG_DUAL_BIT] & ~enc_mode;   // RQ16
      cfg_pairs = st.config_reg[zone_sel_pkg::CFG_PAIRS_LSB +: 3];
      if (enc_mode)                                                       // RQ15
         max_pairs = 3'(zone_sel_pkg::MAX_PAIRS_ENC);
      else if (st.config_reg[zone_sel_pkg::CFG_MUTE_BIT])
         max_pairs = 3'(zone_sel_pkg::MAX_PAIRS_MUTE);
      else if (st.config_reg[zone_sel_pkg::CFG_EDM_BIT] | dual_req)
         max_pairs = 3'(zone_sel_pkg::MAX_PAIRS_EDM);
      else
         max_pairs = 3'(zone_sel_pkg::MAX_PAIRS);                           // RQ12
      if (cfg_pairs == 3'h0)
         eff_pairs = 3'h1;
      else if (cfg_pairs > max_pairs)
         eff_pairs = max_pairs;
      else
         eff_pairs = cfg_pairs;
   end

   // ************************************************************
   // decode of the synchronised selection pairs
   // ************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < zone_sel_pkg::MAX_PAIRS; gi++)
      begin : g_pair
         // pairs above the configured count are masked out
         assign used_mask[gi] = (3'(gi) < eff_pairs);                      // RQ22
         // an off true line adds its binary weight
         assign raw_idx[gi]   = used_mask[gi] & ~st.sync2.true_line[gi];    // RQ13 RQ14 RQ19 RQ20
      end
   endgenerate

   // complement check over used pairs only
   assign raw_err = |(used_mask & ~(st.sync2.true_line ^ st.sync2.inv_line));  // RQ9
   assign raw     = {raw_err, raw_idx};

   // encoder-mode pattern resolution from the settled index
   always_comb
   begin
      pat_sel  = st.active_idx[1:0];
      sel_kind = st.pat_kind[{pat_sel, 1'b0} +: 2];
      any_enc  = 1'b0;
      for (int p = 0; p < zone_sel_pkg::NUM_PATTERNS; p++)
      begin
         if (st.pat_kind[p*2 +: 2] == zone_sel_pkg::PAT_ENCODER)
            any_enc = 1'b1;
      end
      cfg_err  = enc_mode & (~any_enc | (sel_kind == zone_sel_pkg::PAT_UNUSED)  // RQ17
                             | (sel_kind == 2'h3));
      if (!enc_mode)
         area_idx = st.active_idx;                                          // RQ1
      else if (sel_kind == zone_sel_pkg::PAT_ENCODER)
         area_idx = encoder_area;                                           // RQ18
      else
         area_idx = st.pat_area[pat_sel*5 +: 5];
      area_num = {1'b0, area_idx} + 6'h01;
   end

   localparam zone_sel_pkg::settle_state_t SETTLE_WAIT_C = zone_sel_pkg::SETTLE_WAIT;

   // settled value is taken once the delay has run out
   assign commit = (st.settle == SETTLE_WAIT_C) && (raw == st.cand) && (st.ms_cnt >= st.delay_reg[7:0]);

   // ************************************************************
   // AXI4-Lite handshakes and read mux
   // ************************************************************
   assign s_axi_awready = ~st.bvalid & s_axi_awvalid & s_axi_wvalid;
   assign s_axi_wready  = ~st.bvalid & s_axi_awvalid & s_axi_wvalid;
   assign s_axi_arready = ~st.rvalid;
   assign wr_go         = s_axi_awready;
   assign rd_go         = s_axi_arvalid & ~st.rvalid;
   assign wr_hit        = (s_axi_awaddr[7:0] <= zone_sel_pkg::ADDR_PAT_AREA) &&
                          (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr[31:8] == 24'h000000);

   always_comb
   begin
      rd_val = 32'h0000_0000;
      rd_hit = (s_axi_araddr[31:8] == 24'h000000);
      case (s_axi_araddr[7:0])
         zone_sel_pkg::ADDR_CONFIG:   rd_val = {25'h0, st.config_reg[6:0]};
         zone_sel_pkg::ADDR_DELAY:    rd_val = {24'h0, st.delay_reg[7:0]};
         zone_sel_pkg::ADDR_PAT_KIND: rd_val = {24'h0, st.pat_kind[7:0]};
         zone_sel_pkg::ADDR_PAT_AREA: rd_val = {12'h0, st.pat_area[19:0]};
         zone_sel_pkg::ADDR_STATUS:   rd_val = {23'h0, st.settle == SETTLE_WAIT_C, st.fail,
                                                cfg_err, st.active_err, st.active_area};
         default:                     rd_hit = 1'b0;
      endcase
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      next_st = st;
      // two-flop synchroniser on the selection pins
      next_st.sync1 = sel_pins;
      next_st.sync2 = st.sync1;

      // settling: restart on any change, commit after the delay
      if (raw != st.cand)
      begin
         next_st.cand    = raw;                                             // RQ11
         next_st.settle  = zone_sel_pkg::SETTLE_WAIT;
         next_st.pre_cnt = 17'h00000;
         next_st.ms_cnt  = 8'h00;
      end
      else
      begin
         case (st.settle)
            zone_sel_pkg::SETTLE_IDLE:
            begin
               next_st.pre_cnt = 17'h00000;
            end
            zone_sel_pkg::SETTLE_WAIT:
            begin
               if (commit)
               begin
                  next_st.active_idx = st.cand[4:0];                        // RQ11
                  next_st.active_err = st.cand[5];
                  next_st.settle     = zone_sel_pkg::SETTLE_IDLE;
               end
               else if (st.pre_cnt == 17'(CYCLES_PER_MS - 1))
               begin
                  next_st.pre_cnt = 17'h00000;
                  next_st.ms_cnt  = st.ms_cnt + 8'h01;
               end
               else
               begin
                  next_st.pre_cnt = st.pre_cnt + 17'h00001;
               end
            end
            default:
            begin
               next_st.settle = zone_sel_pkg::SETTLE_IDLE;
            end
         endcase
      end

      // output stage
      next_st.dual_eff    = dual_req;                                       // RQ2
      next_st.fail        = st.active_err | cfg_err;                        // RQ21
      next_st.active_area = area_idx;
      next_st.seg_tens    = seg7(4'(area_num / 6'd10));                     // RQ10
      next_st.seg_ones    = seg7(4'(area_num % 6'd10));
      next_st.safe_out[3:2] = {2{~zone_hits.prot1 & ~st.fail}};             // RQ4 RQ21
      if (st.dual_eff)
         next_st.safe_out[1:0] = {2{~zone_hits.prot2 & ~st.fail}};          // RQ5
      else
         next_st.safe_out[1:0] = {2{~zone_hits.prot1 & ~st.fail}};
      // warnings never look at the safety path
      if (st.dual_eff)
         next_st.warn_out = 2'h0;                                           // RQ3
      else
         next_st.warn_out = {~zone_hits.warn1, ~zone_hits.warn2};           // RQ6 RQ7

      // register writes
      if (wr_go)
      begin
         next_st.bvalid = 1'b1;
         next_st.bresp  = wr_hit ? zone_sel_pkg::RESP_OKAY : zone_sel_pkg::RESP_SLVERR;
         if (wr_hit)
         begin
            case (s_axi_awaddr[7:0])
               zone_sel_pkg::ADDR_CONFIG:
                  next_st.config_reg = apply_strb(st.config_reg, s_axi_wdata, s_axi_wstrb) & 32'h0000_007F;
               zone_sel_pkg::ADDR_DELAY:
                  next_st.delay_reg  = apply_strb(st.delay_reg, s_axi_wdata, s_axi_wstrb) & 32'h0000_00FF;
               zone_sel_pkg::ADDR_PAT_KIND:
                  next_st.pat_kind   = apply_strb(st.pat_kind, s_axi_wdata, s_axi_wstrb) & 32'h0000_00FF;
               zone_sel_pkg::ADDR_PAT_AREA:
                  next_st.pat_area   = apply_strb(st.pat_area, s_axi_wdata, s_axi_wstrb) & 32'h000F_FFFF;
               default:
                  next_st.bresp      = zone_sel_pkg::RESP_SLVERR;
            endcase
         end
      end
      else if (st.bvalid & s_axi_bready)
      begin
         next_st.bvalid = 1'b0;
      end

      // register reads
      if (rd_go)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd_val;
         next_st.rresp  = rd_hit ? zone_sel_pkg::RESP_OKAY : zone_sel_pkg::RESP_SLVERR;
      end
      else if (st.rvalid & s_axi_rready)
      begin
         next_st.rvalid = 1'b0;
      end
   end

   // state register with synchronous reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st            <= '0;
         st.cand       <= 6'h00;
         st.fail       <= 1'b1;
         st.settle     <= zone_sel_pkg::SETTLE_WAIT;
         st.config_reg <= zone_sel_pkg::CONFIG_RESET;
         st.delay_reg  <= zone_sel_pkg::DELAY_RESET;
         st.pat_kind   <= zone_sel_pkg::PAT_KIND_RESET;
         st.pat_area   <= zone_sel_pkg::PAT_AREA_RESET;
         st.seg_ones   <= 7'h06;
         st.seg_tens   <= 7'h3F;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign zone1_safe_out_a = st.safe_out[3];
   assign zone1_safe_out_b = st.safe_out[2];
   assign zone2_safe_out_a = st.safe_out[1];
   assign zone2_safe_out_b = st.safe_out[0];
   assign warn_zone_out_1  = st.warn_out[1];
   assign warn_zone_out_2  = st.warn_out[0];
   assign active_area      = st.active_area;
   assign input_error      = st.active_err;
   assign seg_tens         = st.seg_tens;
   assign seg_ones         = st.seg_ones;
   assign s_axi_bvalid     = st.bvalid;
   assign s_axi_bresp      = st.bresp;
   assign s_axi_rvalid     = st.rvalid;
   assign s_axi_rdata      = st.rdata;
   assign s_axi_rresp      = st.rresp;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence raw_moved;
      raw != st.cand;
   endsequence

   sequence waiting_no_commit;
      st.settle == SETTLE_WAIT_C && !commit;
   endsequence

   zone1_off_a: assert property (zone_hits.prot1 |=> !zone1_safe_out_a && !zone1_safe_out_b)  // RQ4
      else $error("zone1 safety pair on with obstacle");
   dual_zone2_a: assert property (st.dual_eff && !st.fail |=> zone2_safe_out_a == !$past(zone_hits.prot2))  // RQ5
      else $error("zone2 pair not following zone2");
   warn_off_a: assert property (!st.dual_eff && zone_hits.warn2 |=> !warn_zone_out_2)  // RQ6
      else $error("warn_zone_out_2 on with obstacle");
   dual_nowarn_a: assert property (st.dual_eff |=> !warn_zone_out_1 && !warn_zone_out_2)  // RQ3
      else $error("warning active in dual protection");
   fail_safe_a: assert property (st.fail |=> !zone1_safe_out_a && !zone2_safe_out_b)  // RQ21
      else $error("safety output on during selection fault");
   warn_indep_a: assert property (!st.dual_eff && st.fail && !zone_hits.warn1 |=> warn_zone_out_1)  // RQ7
      else $error("warning disturbed by safety fault");
   enc_excl_a: assert property (enc_mode |-> !dual_req && eff_pairs <= 3'h2)  // RQ16
      else $error("encoder mode allows dual or too many pairs");
   pair_limit_a: assert property (eff_pairs >= 3'h1 && eff_pairs <= 3'h5 && eff_pairs <= max_pairs)  // RQ15
      else $error("effective pair count out of range");
   settle_hold_a: assert property (raw_moved or waiting_no_commit |=> $stable(st.active_idx))  // RQ11
      else $error("area taken before settling");
   error_flag_a: assert property (raw_err && raw == st.cand && commit |=> st.active_err)  // RQ9
      else $error("complement error not raised");
   display_a: assert property (##1 seg_ones == seg7(4'(({1'b0, $past(area_idx)} + 6'h01) % 6'd10)))  // RQ10
      else $error("display does not show active area");

endmodule : zone_output_area_select

`default_nettype wire

// ### verif/sel_driver.sv
// controller model driving the complementary area selection pairs
`timescale 1ns/1ps
`default_nettype none

module sel_driver (
   input  wire logic                    aclk,
   input  wire logic [4:0]              area_idx,
   input  wire logic [4:0]              bad_pair,
   output var  zone_sel_pkg::sel_pins_t sel_pins
);
   // true line off adds its weight; a set bad_pair bit makes that pair equal
   always_ff @(posedge aclk)
   begin
      sel_pins.true_line <= ~area_idx;
      sel_pins.inv_line  <= area_idx ^ bad_pair;
   end
endmodule : sel_driver

`default_nettype wire

// ### verif/zone_output_area_select_test.sv
// self-checking bench for the zone output and area select block
`timescale 1ns/1ps
`default_nettype none

module zone_output_area_select_test;
   typedef struct packed {
      logic [7:0] cfg;
      logic [4:0] idx;
      logic [4:0] bad;
      logic [3:0] hits;
      logic [4:0] area;
      logic [5:0] outs;
      logic       err;
   } row_t;
   localparam int CPM = 4;
   localparam logic [6:0] SEG [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
   // cfg idx bad hits area outs{z1a z1b z2a z2b w1 w2} err
   row_t rows [15] = '{'{8'h05, 5'h00, 5'h00, 4'h0, 5'h00, 6'h3F, 1'h0}, '{8'h05, 5'h1F, 5'h00, 4'h0, 5'h1F, 6'h3F, 1'h0},
      '{8'h05, 5'h12, 5'h00, 4'h8, 5'h12, 6'h03, 1'h0}, '{8'h04, 5'h1F, 5'h00, 4'h2, 5'h0F, 6'h3D, 1'h0},
      '{8'h45, 5'h1F, 5'h00, 4'h1, 5'h0F, 6'h3E, 1'h0}, '{8'h25, 5'h1F, 5'h00, 4'h0, 5'h03, 6'h3F, 1'h0},
      '{8'h03, 5'h1D, 5'h00, 4'h0, 5'h05, 6'h3F, 1'h0}, '{8'h02, 5'h0E, 5'h10, 4'h0, 5'h02, 6'h3F, 1'h0},
      '{8'h01, 5'h1F, 5'h00, 4'h0, 5'h01, 6'h3F, 1'h0}, '{8'h0C, 5'h05, 5'h00, 4'h4, 5'h05, 6'h30, 1'h0},
      '{8'h0C, 5'h05, 5'h00, 4'h8, 5'h05, 6'h0C, 1'h0}, '{8'h0C, 5'h05, 5'h00, 4'h2, 5'h05, 6'h3C, 1'h0},
      '{8'h12, 5'h1F, 5'h00, 4'h0, 5'h14, 6'h3F, 1'h0}, '{8'h05, 5'h03, 5'h01, 4'h0, 5'h00, 6'h03, 1'h1},
      '{8'h05, 5'h03, 5'h00, 4'h0, 5'h03, 6'h3F, 1'h0}};
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, input_error;
   logic        zone1_safe_out_a, zone1_safe_out_b, zone2_safe_out_a, zone2_safe_out_b, warn_zone_out_1, warn_zone_out_2;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [4:0]  area_idx, bad_pair, encoder_area, active_area;
   logic [6:0]  seg_tens, seg_ones;
   logic [3:0]  s_axi_wstrb;
   int          n_fail, check_count;
   zone_sel_pkg::zone_hits_t zone_hits;
   zone_sel_pkg::sel_pins_t  sel_pins;

   zone_output_area_select #(.CYCLES_PER_MS(CPM)) zone_output_area_select_i (.aclk, .aresetn, .sel_pins,
      .zone_hits, .encoder_area, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .zone1_safe_out_a,
      .zone1_safe_out_b, .zone2_safe_out_a, .zone2_safe_out_b, .warn_zone_out_1, .warn_zone_out_2,
      .active_area, .input_error, .seg_tens, .seg_ones);
   sel_driver sel_driver_i (.aclk, .area_idx, .bad_pair, .sel_pins);

   // ************************************************************
   // bus and check tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // write: each channel released at its own handshake, then wait for the response
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad = 1'h0;
      logic dd = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= {24'h000000, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         ad |= s_axi_awready;
         dd |= s_axi_wready;
         s_axi_awvalid <= !ad;
         s_axi_wvalid <= !dd;
      end
      while (!(ad && dd));
      while (!s_axi_bvalid) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= {24'h000000, a};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      while (!s_axi_rvalid) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   // ************************************************************
   // clock, watchdog and test sequence
   // ************************************************************
   initial
   begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   initial
   begin
      repeat (12000) @(posedge aclk);
      n_fail++;
      wrap_up();
   end

   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      {area_idx, bad_pair, zone_hits} = 14'h0000;
      encoder_area = 5'h14;
      s_axi_wstrb = 4'hF;
      n_fail = 0;
      check_count = 0;
      repeat (16) @(posedge aclk);
      chk("reset outs", {zone1_safe_out_a, zone2_safe_out_a, warn_zone_out_1}, 3'h0);
      chk("reset display", {seg_tens, seg_ones}, {7'h3F, 7'h06});
      aresetn <= 1'h1;
      rd(zone_sel_pkg::ADDR_DELAY, rdat, rs);
      chk("delay", rdat, 32'h0000001E);
      rd(zone_sel_pkg::ADDR_CONFIG, rdat, rs);
      chk("config", rdat, 32'h00000005);
      rd(8'h20, rdat, rs);
      chk("unmapped", rs, 2'h2);
      wr(zone_sel_pkg::ADDR_STATUS, 32'h00000000, rs);
      chk("status write", rs, 2'h2);
      $display("test registers done");
      // each row: configure, present pins and hits, let the selection settle
      foreach (rows[i])
      begin
         wr(zone_sel_pkg::ADDR_CONFIG, {24'h000000, rows[i].cfg}, rs);
         area_idx <= rows[i].idx;
         bad_pair <= rows[i].bad;
         zone_hits <= rows[i].hits;
         repeat (160) @(posedge aclk);
         chk("outs", {zone1_safe_out_a, zone1_safe_out_b, zone2_safe_out_a, zone2_safe_out_b,
            warn_zone_out_1, warn_zone_out_2}, rows[i].outs);
         chk("error", input_error, rows[i].err);
         if (!rows[i].err)
         begin
            chk("area", active_area, rows[i].area);
            chk("ones", seg_ones, SEG[(rows[i].area + 1) % 10]);
            chk("tens", seg_tens, SEG[(rows[i].area + 1) / 10]);
         end
         $display("test row %0d done", i);
      end
      // one-cycle reaction to a protection hit, then the settling delay
      zone_hits <= 4'h8;
      repeat (2) @(posedge aclk);
      chk("prot1 fast", zone1_safe_out_b, 1'h0);
      zone_hits <= 4'h0;
      area_idx <= 5'h07;
      repeat (100) @(posedge aclk);
      chk("area early", active_area, 5'h03);
      repeat (40) @(posedge aclk);
      chk("area late", active_area, 5'h07);
      $display("test timing done");
      wr(zone_sel_pkg::ADDR_PAT_KIND, 32'h00000046, rs);
      wr(zone_sel_pkg::ADDR_PAT_AREA, 32'h00048000, rs);
      wr(zone_sel_pkg::ADDR_CONFIG, 32'h00000012, rs);
      repeat (160) @(posedge aclk);
      chk("static area", active_area, 5'h09);
      area_idx <= 5'h02;
      repeat (160) @(posedge aclk);
      chk("unused pattern", zone1_safe_out_a, 1'h0);
      aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      chk("mid reset", {zone2_safe_out_b, warn_zone_out_2, s_axi_bvalid, seg_ones}, 10'h006);
      aresetn <= 1'h1;
      $display("test awkward done");
      wrap_up();
   end
endmodule : zone_output_area_select_test

`default_nettype wire
